// file: verilog/nvol_latch.sv
// Nonvolatile octal latch/register: user storage, per-bit shadow, restore.
// Assumes host inputs synchronous to core_clk; power_good is the supply check.
//
// Overview of operation
// - Eight independent bits, each with input, output, user cell and shadow cell.
// - Output enable low drives stored state; high releases all outputs.
// - Transparent variant follows inputs while control high, freezes on fall.
// - Register variant captures inputs only on control rising edge.
// - Without a load condition the state holds and shows if enabled.
// - Loading continues while outputs are released.
// - Any change of latched state starts a shadow write unprompted.
// - A shadow write commits within 500 ns of its start.
// - Shadow writes happen only when the latched value differs.
// - Comparison and writing are done per bit.
// - Below threshold all shadow updates are blocked.
// - Below threshold host loads of the user latch are ignored.
// - Restore starts at threshold and ends within the restore duration.
// - Restore puts shadow on internal data and gives exactly one load pulse.
// - After restore behaviour matches pre-loss state, then normal operation.
// - Transparent values passing through are not saved; only the held one.
// - Shadow writes that fall behind catch up after a burst.
`timescale 1ns/1ps
module nvol_latch
    import nvol_pkg::*;
#(
    parameter int WIDTH        = 8,
    parameter bit TRANSPARENT  = 1'b1,
    parameter int WRITE_CYC    = SHADOW_WRITE_CYC,
    parameter int RESTORE_CYCS = RESTORE_CYC,
    parameter int HOLD_CYCS    = POWER_UP_HOLD_CYC
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // Supply monitor
    input  wire logic             power_good,
    // Host side
    input  wire logic [WIDTH-1:0] data_inputs,
    input  wire logic             latch_ctl,
    input  wire logic             oe_n,
    // Output pins
    output logic      [WIDTH-1:0] data_outputs,
    output logic      [WIDTH-1:0] data_outputs_oe,
    // Status
    output logic                  restore_done,
    output logic                  shadow_busy
);

    initial begin
        if (WIDTH != 8 || RESTORE_CYCS < 2 || RESTORE_CYCS > 65535 || HOLD_CYCS > 65535) begin
            $error("nvol_latch: unsupported parameter");
        end
    end

    nvol_host_t       host;
    nvol_pwr_t        pwr_q, pwr_d;
    logic [15:0]      tmr_q, tmr_d;
    logic [WIDTH-1:0] user_q, user_d;
    logic [WIDTH-1:0] held_q, held_d;
    logic             ctl_q, ctl_d;
    logic             pulse_q, pulse_d;
    logic [WIDTH-1:0] out_q, out_d;
    logic [WIDTH-1:0] oe_q, oe_d;
    logic             done_q, done_d;
    logic             busy_q, busy_d;
    logic [WIDTH-1:0] shadow;
    logic [WIDTH-1:0] bit_busy;

    assign host = '{data: data_inputs, latch_ctl: latch_ctl, oe_n: oe_n};

    // ==========================================================
    // Power sequencing and user storage
    always_comb begin
        pwr_d   = pwr_q;
        tmr_d   = tmr_q;
        user_d  = user_q;
        held_d  = held_q;
        pulse_d = 1'b0;
        done_d  = done_q;
        ctl_d   = power_good ? host.latch_ctl : 1'b0;
        unique case (pwr_q)
            NVOL_PWR_OFF: begin
                done_d = 1'b0;
                if (power_good) begin
                    pwr_d   = NVOL_PWR_RESTORE;
                    tmr_d   = 16'(RESTORE_CYCS - 1);
                    user_d  = shadow;
                    held_d  = shadow;
                    pulse_d = 1'b1;
                end
            end
            NVOL_PWR_RESTORE: begin
                if (!power_good) begin
                    pwr_d = NVOL_PWR_OFF;
                end else if (tmr_q == 16'h0000) begin
                    pwr_d  = NVOL_PWR_RUN;
                    done_d = 1'b1;
                end else begin
                    tmr_d = tmr_q - 16'h0001;
                end
            end
            NVOL_PWR_RUN: begin
                if (!power_good) begin
                    pwr_d = NVOL_PWR_OFF;
                end else if (TRANSPARENT) begin
                    if (host.latch_ctl) begin
                        user_d = host.data;
                    end
                    if (ctl_q && !host.latch_ctl) begin
                        held_d = user_q;
                    end
                end else if (host.latch_ctl && !ctl_q) begin
                    user_d = host.data;
                    held_d = host.data;
                end
            end
        endcase
        // Without a load condition user_d keeps user_q
        out_d  = (pwr_q == NVOL_PWR_OFF) ? user_q : user_d;
        oe_d   = host.oe_n ? {WIDTH{1'b0}} : {WIDTH{1'b1}};
        busy_d = |bit_busy;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pwr_q   <= NVOL_PWR_OFF;
            tmr_q   <= 16'h0000;
            ctl_q   <= 1'b0;
            pulse_q <= 1'b0;
            out_q   <= '0;
            oe_q    <= '0;
            done_q  <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            pwr_q   <= pwr_d;
            tmr_q   <= tmr_d;
            ctl_q   <= ctl_d;
            pulse_q <= pulse_d;
            out_q   <= out_d;
            oe_q    <= oe_d;
            done_q  <= done_d;
            busy_q  <= busy_d;
        end
        // User cells are rebuilt from the shadow at every restore
        user_q <= user_d;
        held_q <= held_d;
    end

    assign data_outputs    = out_q;
    assign data_outputs_oe = oe_q;
    assign restore_done    = done_q;
    assign shadow_busy     = busy_q;

    // ==========================================================
    // Per-bit shadow cells; each runs independently and writes its latest value once idle after a burst
    generate
        for (genvar i = 0; i < WIDTH; i++) begin : g_bit
            nvol_shadow_bit #(
                .WRITE_CYC (WRITE_CYC),
                .RESET_VAL (NVOL_RESET_SHADOW[i])
            ) u_shadow (
                .core_clk   (core_clk),
                .rst        (rst),
                .power_good (power_good && pwr_q == NVOL_PWR_RUN),
                .user_bit   (held_q[i]),
                .shadow_bit (shadow[i]),
                .busy       (bit_busy[i])
            );
        end
    endgenerate

    // ==========================================================
    // Checks
    property p_oe_follows;
        @(posedge core_clk) disable iff (rst)
        ##1 (data_outputs_oe == ($past(oe_n) ? 8'h00 : 8'hFF));
    endproperty
    a_oe_follows: assert property (p_oe_follows) else $error("output enable mismatch");

    property p_blocked_low;
        @(posedge core_clk) disable iff (rst)
        (!power_good && pwr_q != NVOL_PWR_OFF) ##1 (pwr_q == NVOL_PWR_OFF) |=> $stable(user_q);
    endproperty
    a_blocked_low: assert property (p_blocked_low) else $error("user load below threshold");

    property p_single_pulse;
        @(posedge core_clk) disable iff (rst)
        pulse_q |=> !pulse_q [*8];
    endproperty
    a_single_pulse: assert property (p_single_pulse) else $error("more than one restore pulse");

    property p_restore_len;
        @(posedge core_clk) disable iff (rst || !power_good)
        $rose(pulse_q) |-> ##[1:120] restore_done;
    endproperty
    a_restore_len: assert property (p_restore_len) else $error("restore too long");

    property p_hold;
        @(posedge core_clk) disable iff (rst)
        (pwr_q == NVOL_PWR_RUN && !TRANSPARENT && !(latch_ctl && !ctl_q) && power_good) |=> $stable(user_q);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without edge");

    property p_transp;
        @(posedge core_clk) disable iff (rst)
        (pwr_q == NVOL_PWR_RUN && power_good && TRANSPARENT && latch_ctl) |=> (user_q == $past(data_inputs));
    endproperty
    a_transp: assert property (p_transp) else $error("latch not transparent");

    property p_out_shows;
        @(posedge core_clk) disable iff (rst)
        (pwr_q == NVOL_PWR_RUN) ##1 (pwr_q == NVOL_PWR_RUN) |-> (data_outputs == $past(user_q) || data_outputs == user_q);
    endproperty
    a_out_shows: assert property (p_out_shows) else $error("outputs do not show state");

    property p_restore_value;
        @(posedge core_clk) disable iff (rst)
        pulse_q |-> (user_q == $past(shadow));
    endproperty
    a_restore_value: assert property (p_restore_value) else $error("restore loaded wrong value");

endmodule

// file: verilog/nvol_pkg.sv
// Package for the nonvolatile octal latch: timing counts, states, carriers.
// Assumes a single 100 MHz core clock; all times are converted to cycles here.
package nvol_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS     = 10;
    localparam int SHADOW_WRITE_NS   = 500;
    localparam int RESTORE_NS        = 1000;
    localparam int POWER_UP_HOLD_NS  = 2000;
    // Longest times round down, at least one cycle
    localparam int SHADOW_WRITE_CYC  = (SHADOW_WRITE_NS / CLK_PERIOD_NS) < 1 ? 1 : (SHADOW_WRITE_NS / CLK_PERIOD_NS);
    localparam int RESTORE_CYC       = (RESTORE_NS / CLK_PERIOD_NS) < 1 ? 1 : (RESTORE_NS / CLK_PERIOD_NS);
    localparam int POWER_UP_HOLD_CYC = (POWER_UP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Reset values
    localparam logic [7:0] NVOL_RESET_SHADOW = 8'h00;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        NVOL_PWR_OFF,
        NVOL_PWR_RESTORE,
        NVOL_PWR_RUN
    } nvol_pwr_t;

    typedef enum logic [1:0] {
        NVOL_BIT_IDLE,
        NVOL_BIT_WRITE
    } nvol_bit_t;

    typedef struct packed {
        logic [7:0] data;
        logic       latch_ctl;
        logic       oe_n;
    } nvol_host_t;

endpackage

// file: verilog/nvol_shadow_bit.sv
// One nonvolatile shadow cell with its own write sequencer.
// Assumes the user bit is stable from the core clock; power_good gates writes.
`timescale 1ns/1ps
module nvol_shadow_bit
    import nvol_pkg::*;
#(
    parameter int WRITE_CYC = SHADOW_WRITE_CYC,
    parameter bit RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // Control
    input  wire logic power_good,
    input  wire logic user_bit,
    // Shadow state
    output logic      shadow_bit,
    output logic      busy
);

    initial begin
        if (WRITE_CYC < 1 || WRITE_CYC > 65535) begin
            $error("nvol_shadow_bit: WRITE_CYC out of range");
        end
    end

    nvol_bit_t   state_q, state_d;
    logic [15:0] cnt_q,   cnt_d;
    logic        shadow_q, shadow_d;
    logic        target_q, target_d;

    // ==========================================================
    // Write sequencer
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        shadow_d = shadow_q;
        target_d = target_q;
        unique case (state_q)
            NVOL_BIT_IDLE: begin
                // Only a differing bit costs an endurance cycle
                if (power_good && user_bit != shadow_q) begin
                    state_d  = NVOL_BIT_WRITE;
                    target_d = user_bit;
                    cnt_d    = 16'(WRITE_CYC - 1);
                end
            end
            NVOL_BIT_WRITE: begin
                if (!power_good) begin
                    state_d = NVOL_BIT_IDLE;
                end else if (cnt_q == 16'h0000) begin
                    shadow_d = target_q;
                    state_d  = NVOL_BIT_IDLE;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end
        endcase
    end

    // Shadow cell survives supply loss; only rst, the factory clear, empties it.
    // An unknown cell would never compare unequal and so never be written.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q  <= NVOL_BIT_IDLE;
            cnt_q    <= 16'h0000;
            shadow_q <= RESET_VAL;
            target_q <= RESET_VAL;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            shadow_q <= shadow_d;
            target_q <= target_d;
        end
    end

    assign shadow_bit = shadow_q;
    assign busy       = (state_q == NVOL_BIT_WRITE);

    property p_commit_in_time;
        @(posedge core_clk) disable iff (rst || !power_good)
        (state_q == NVOL_BIT_IDLE && power_good && user_bit != shadow_q) |-> ##[1:60] (state_q == NVOL_BIT_IDLE);
    endproperty
    a_commit_in_time: assert property (p_commit_in_time) else $error("shadow write overran");

    property p_no_write_low;
        @(posedge core_clk) disable iff (rst)
        !power_good |=> $stable(shadow_q);
    endproperty
    a_no_write_low: assert property (p_no_write_low) else $error("shadow changed below threshold");

    property p_no_needless;
        @(posedge core_clk) disable iff (rst)
        (state_q == NVOL_BIT_IDLE && user_bit == shadow_q) |=> (state_q == NVOL_BIT_IDLE);
    endproperty
    a_no_needless: assert property (p_no_needless) else $error("write on equal bit");

endmodule

// file: verif/nvol_host_model.sv
// Host-side partner: drives data, latch control, output enable and the supply check.
// Assumes one core clock; every change lands 1 ns after a rising edge, except a supply drop with quiet 0, which lands 1 ns after the previous change.
`timescale 1ns/1ps
module nvol_host_model
    import nvol_pkg::*;
#(
    parameter int HOLD_CYCS    = POWER_UP_HOLD_CYC,
    parameter int RESTORE_CYCS = RESTORE_CYC
) (
    // Clock and status
    input  wire logic core_clk,
    input  wire logic restore_done,
    // Drive towards the device
    output nvol_host_t host,
    output logic       power_good
);
    initial begin
        host = '{data: 8'h00, latch_ctl: 1'b0, oe_n: 1'b1};
        power_good = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic set_oe(input logic v);
        step(1);
        host.oe_n = v;
    endtask

    task automatic set_ctl(input logic c, input logic [7:0] v);
        step(1);
        host.latch_ctl = c;
        host.data = v;
    endtask

    // One high cycle, then low; data is kept so a transparent load holds it
    task automatic pulse(input logic [7:0] v);
        set_ctl(1'b1, v);
        set_ctl(1'b0, v);
    endtask

    // ==========================================================
    // Supply cycle with a refused load attempt while the supply is low
    task automatic power_cycle(input int quiet, input logic [7:0] try_v, output int wait_cyc);
        step(quiet);
        power_good = 1'b0;
        pulse(try_v);
        step(2);
        power_good = 1'b1;
        wait_cyc = 0;
        while (restore_done !== 1'b1 && wait_cyc < RESTORE_CYCS + 8) begin
            step(1);
            wait_cyc++;
        end
        step(HOLD_CYCS);
    endtask
endmodule

// file: verif/tb_top.sv
// Self-checking bench: both variants side by side, fed by one host model.
// Assumes the design package; counts are the package defaults, not shortened.
`timescale 1ns/1ps
module tb_top
    import nvol_pkg::*;
;
    localparam int WCYC = SHADOW_WRITE_CYC;
    localparam int RCYC = RESTORE_CYC;

    logic       core_clk;
    logic       rst;
    logic       power_good;
    nvol_host_t host;
    logic [7:0] q      [2];
    logic [7:0] q_oe   [2];
    logic       done   [2];
    logic       busy   [2];
    int         n_mismatch = 0;
    int         checks_done = 0;
    int         w;
    logic [1:0] seen;
    logic [7:0] v;
    int         nb0;
    int         nb1;

    // ==========================================================
    // Devices: index 0 transparent, index 1 edge register
    for (genvar k = 0; k < 2; k++) begin : g_var
        nvol_latch #(.TRANSPARENT(k == 0)) i_nvol_latch (
            .core_clk(core_clk), .rst(rst), .power_good(power_good), .data_inputs(host.data),
            .latch_ctl(host.latch_ctl), .oe_n(host.oe_n), .data_outputs(q[k]),
            .data_outputs_oe(q_oe[k]), .restore_done(done[k]), .shadow_busy(busy[k]));
    end

    nvol_host_model i_nvol_host_model (
        .core_clk(core_clk), .restore_done(done[0]), .host(host), .power_good(power_good));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ==========================================================
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_q(input logic [7:0] e0, input logic [7:0] e1);
        chk(q[0], e0);
        chk(q[1], e1);
    endtask

    // Bounded wait until neither shadow sequencer is busy. Busy lags a load by
    // two cycles and dips for one cycle between a commit and a restart, so
    // two quiet samples in a row are needed.
    task automatic wait_idle(input int lim, output int n);
        int quiet;
        n = 0;
        quiet = 0;
        tick(2);
        while (quiet < 2 && n < lim) begin
            if ((busy[0] | busy[1]) === 1'b0) begin
                quiet++;
            end else begin
                quiet = 0;
            end
            tick(1);
            n++;
        end
    endtask

    task automatic watch_busy(output logic [1:0] s, output int n0, output int n1);
        s = 2'b00;
        n0 = 0;
        n1 = 0;
        repeat (WCYC + 4) begin
            tick(1);
            s = s | {busy[1], busy[0]};
            n0 += int'(busy[0] === 1'b1);
            n1 += int'(busy[1] === 1'b1);
        end
    endtask

    task automatic test_done;
        $display("Comparisons: %0d, mismatches: %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Whole run is about two thousand cycles; this leaves ample margin
    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        test_done();
    end

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(32'hFC4AE26C));
        rst = 1'b1;
        repeat (5) @(posedge core_clk);
        #1 rst = 1'b0;
        i_nvol_host_model.power_cycle(0, 8'h00, w);
        chk({6'h00, done[1], done[0]}, 8'h03);
        i_nvol_host_model.set_oe(1'b1);
        tick(2);
        chk(q_oe[0] | q_oe[1], 8'h00);
        i_nvol_host_model.set_oe(1'b0);
        tick(2);
        chk(q_oe[0] & q_oe[1], 8'hFF);
        i_nvol_host_model.set_oe(1'b1);
        i_nvol_host_model.pulse(8'h5A);
        i_nvol_host_model.set_oe(1'b0);
        tick(2);
        chk_q(8'h5A, 8'h5A);
        i_nvol_host_model.set_ctl(1'b0, 8'hC3);
        tick(3);
        chk_q(8'h5A, 8'h5A);
        wait_idle(100, w);
        i_nvol_host_model.pulse(8'h3C);
        watch_busy(seen, nb0, nb1);
        chk({6'h00, seen}, 8'h03);
        chk(8'(nb0), 8'(WCYC));
        chk(8'(nb1), 8'(WCYC));
        wait_idle(WCYC + 4, w);
        chk(8'(w > WCYC + 3), 8'h00);
        i_nvol_host_model.pulse(8'h3C);
        watch_busy(seen, nb0, nb1);
        chk({6'h00, seen}, 8'h00);
        i_nvol_host_model.set_ctl(1'b1, 8'hA5);
        tick(2);
        chk_q(8'hA5, 8'hA5);
        i_nvol_host_model.set_ctl(1'b1, 8'h96);
        tick(2);
        chk_q(8'h96, 8'hA5);
        chk({7'h00, busy[0]}, 8'h00);
        i_nvol_host_model.set_ctl(1'b0, 8'h96);
        wait_idle(WCYC * 4, w);
        i_nvol_host_model.pulse(8'h81);
        wait_idle(WCYC * 4, w);
        i_nvol_host_model.power_cycle(2, 8'h7E, w);
        chk(8'(w > RCYC + 3), 8'h00);
        chk_q(8'h81, 8'h81);
        // Supply drops before the new value can be committed
        i_nvol_host_model.pulse(8'h18);
        i_nvol_host_model.power_cycle(0, 8'hE7, w);
        chk_q(8'h81, 8'h81);
        i_nvol_host_model.pulse(8'h42);
        tick(1);
        chk_q(8'h42, 8'h42);
        repeat (16) begin
            v = 8'($urandom);
            i_nvol_host_model.pulse(v);
        end
        wait_idle(200, w);
        chk(8'(w >= 200), 8'h00);
        i_nvol_host_model.power_cycle(2, ~v, w);
        chk_q(v, v);
        wait_idle(WCYC * 4, w);
        i_nvol_host_model.pulse(v ^ 8'h10);
        wait_idle(WCYC * 4, w);
        i_nvol_host_model.power_cycle(2, v, w);
        chk_q(v ^ 8'h10, v ^ 8'h10);
        test_done();
    end
endmodule
